// ---- verilog/cdl_consts.svh ----
// Purpose: Offsets, field positions, reset values and mode codes of the counter.
// Assumes: Registers sit on 32-bit Wishbone words at byte addresses.
// Notes:   Definitions only.
`ifndef CDL_CONSTS_SVH
`define CDL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CDL_OFS_CTRL      8'h00
`define CDL_OFS_INCR      8'h04
`define CDL_OFS_ACCUM     8'h08
`define CDL_OFS_PINCTL    8'h0C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CDL_MODE_LSB      26
`define CDL_MODE_MSB      30
`define CDL_PLL_DIVIDER_SELECT_LSB    23
`define CDL_PLL_DIVIDER_SELECT_MSB    25
`define CDL_PC_DIR_A      0
`define CDL_PC_DIR_B      1
`define CDL_PC_LAT_A      2
`define CDL_PC_LAT_B      3
`define CDL_PC_PIN_A      4
`define CDL_PC_PIN_B      5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CDL_RST_MODE      5'h00
`define CDL_RST_PLL_DIVIDER_SELECT    3'h0
`define CDL_RST_WORD      32'h0000_0000
`define CDL_RST_PINCTL    4'h0

// ----------------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------------
`define CDL_MODE_OFF      5'h00
`define CDL_MODE_DUTY_SE  5'h06
`define CDL_MODE_DUTY_DF  5'h07
`define CDL_MODE_NEVER    5'h10
`define CDL_MODE_ALWAYS   5'h1F

`endif

// ---- verilog/cdl_pkg.sv ----
// Purpose: Types shared by the counter duty and logic pin mode block.
// Assumes: Constants come from cdl_consts.svh.
// Notes:   No timescale; types only.
package cdl_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef logic [4:0] cdl_mode_t;

   // Registered views of the pins.
   typedef struct packed {
      logic a_s1;
      logic a_s2;
      logic b_s1;
   } cdl_pins_t;

   // Decoded behaviour of the current mode.
   typedef struct packed {
      logic accumulate;
      logic duty;
      logic diff;
      logic feedback;
   } cdl_cond_t;

endpackage

// ---- verilog/cdl_cond.sv ----
// Purpose: Decodes the counter mode into accumulate and pin drive controls.
// Assumes: Pin views are already registered once and twice.
// Notes:   Purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "cdl_consts.svh"

module cdl_cond (
   // Mode and pins
   input  wire cdl_pkg::cdl_mode_t mode_i,
   input  wire cdl_pkg::cdl_pins_t pins_i,
   // Decoded controls
   output var  cdl_pkg::cdl_cond_t cond_o
);

   // -------------------------------------------------------------------------
   // Group decode
   // -------------------------------------------------------------------------
   wire logic grp_duty;
   wire logic grp_pin;
   wire logic grp_logic;
   wire logic [1:0] eq_idx;
   wire logic logic_hit;
   wire logic level_hit;
   wire logic edge_hit;
   wire logic pin_hit;

   assign grp_duty  = (mode_i == `CDL_MODE_DUTY_SE) || (mode_i == `CDL_MODE_DUTY_DF);
   assign grp_pin   = (mode_i[4:3] == 2'b01);
   assign grp_logic = mode_i[4];

   assign eq_idx    = {pins_i.b_s1, pins_i.a_s1};
   // truth table
   // The low four mode bits form the truth table of the two-input equation.
   assign logic_hit = mode_i[eq_idx];

   assign level_hit = pins_i.a_s1 ^ mode_i[2];
   assign edge_hit  = mode_i[2] ? (~pins_i.a_s1 & pins_i.a_s2) : (pins_i.a_s1 & ~pins_i.a_s2);
   assign pin_hit   = mode_i[1] ? edge_hit : level_hit;

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // accumulate select
   assign cond_o.accumulate = grp_duty | (grp_logic & logic_hit) | (grp_pin & pin_hit);
   assign cond_o.duty       = grp_duty;
   assign cond_o.diff       = (mode_i == `CDL_MODE_DUTY_DF);
   assign cond_o.feedback   = grp_pin & mode_i[0];

endmodule

`default_nettype wire

// ---- verilog/cdl_counter.sv ----
// Purpose: One counter with duty, logic and pin-state modes on two pins.
// Assumes: Classic Wishbone slave, 32-bit data, pins synchronous to clk_i.
// Notes:   Modes outside the three groups hold the accumulator and drive nothing.
//
// What this block does
// - Codes 00110 and 00111 drive the accumulator carry onto the first pin.
// - In duty modes the first pin is high on cycles where the accumulator wraps.
// - Duty output high fraction equals increment over two to the thirty-two.
// - Logic modes 10000-11111 read both pins and add only when equation holds.
// - Logic mode 10000 never accumulates, like counter off.
// - Logic mode 11111 adds the increment on every clock cycle.
// - Logic equations use pin values registered one clock earlier.
// - Equations for codes 10001 through 10111.
// - Equations for codes 11000 through 11110.
// - Pin-state modes look at first pin; level single, edges double registered.
// - Pin-state conditions high, rising, low, falling; odd codes add feedback.
// - Feedback modes drive second pin with inverse of sampled first pin.
// - The PLL divider select field is ignored in these modes.
`timescale 1ns/100ps
`default_nettype none
`include "cdl_consts.svh"

module cdl_counter (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // First pin
   input  wire logic        first_pin_i,
   output logic             first_pin_o,
   output logic             first_pin_oe_o,
   // Second pin
   input  wire logic        second_pin_i,
   output logic             second_pin_o,
   output logic             second_pin_oe_o
);

   // -------------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------------
   // Merges write data into an old word under the byte enables.
   function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   cdl_pkg::cdl_mode_t mode_q;
   logic [2:0]         pll_divider_select_q;
   logic [31:0]        incr_q;
   logic [31:0]        acc_q;
   logic [31:0]        acc_d;
   logic               dir_a_q;
   logic               dir_b_q;
   logic               lat_a_q;
   logic               lat_b_q;
   logic               first_s1_q;
   logic               first_s2_q;
   logic               second_s1_q;
   logic               ack_q;
   logic [31:0]        dat_q;
   logic               pin_a_q;
   logic               pin_b_q;

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   wire logic        req;
   wire logic        wr_take;
   wire logic        hit_ctrl;
   wire logic        hit_incr;
   wire logic        hit_acc;
   wire logic        hit_pin;
   wire logic        ctrl_wr;
   wire logic        incr_wr;
   wire logic        acc_wr;
   wire logic        pin_wr;
   wire logic [31:0] ctrl_word;
   wire logic [31:0] pin_word;
   wire logic [31:0] rd_word;
   wire logic [31:0] ctrl_new;
   wire logic [31:0] pin_new;

   assign req      = wb_cyc_i & wb_stb_i;
   // A write lands at the edge where ack is already high.
   assign wr_take  = req & wb_we_i & ack_q;
   assign hit_ctrl = (wb_adr_i == `CDL_OFS_CTRL);
   assign hit_incr = (wb_adr_i == `CDL_OFS_INCR);
   assign hit_acc  = (wb_adr_i == `CDL_OFS_ACCUM);
   assign hit_pin  = (wb_adr_i == `CDL_OFS_PINCTL);
   assign ctrl_wr  = wr_take & hit_ctrl;
   assign incr_wr  = wr_take & hit_incr;
   assign acc_wr   = wr_take & hit_acc;
   assign pin_wr   = wr_take & hit_pin;

   assign ctrl_word = {1'b0, mode_q, pll_divider_select_q, 23'h00_0000};
   assign pin_word  = {26'h000_0000, second_s1_q, first_s1_q,
                       lat_b_q, lat_a_q, dir_b_q, dir_a_q};
   assign rd_word   = hit_ctrl ? ctrl_word :
                      hit_incr ? incr_q :
                      hit_acc  ? acc_q :
                      hit_pin  ? pin_word : 32'h0000_0000;
   assign ctrl_new  = merge_sel(ctrl_word, wb_dat_i, wb_sel_i);
   assign pin_new   = merge_sel(pin_word, wb_dat_i, wb_sel_i);

   // -------------------------------------------------------------------------
   // Bus handshake
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= `CDL_RST_WORD;
      end else begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q) begin
            dat_q <= rd_word;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q   <= `CDL_RST_MODE;
         pll_divider_select_q <= `CDL_RST_PLL_DIVIDER_SELECT;
         incr_q   <= `CDL_RST_WORD;
         dir_a_q  <= 1'b0;
         dir_b_q  <= 1'b0;
         lat_a_q  <= 1'b0;
         lat_b_q  <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            mode_q   <= ctrl_new[`CDL_MODE_MSB:`CDL_MODE_LSB];
            // divider stored only
            // Held for software readback; no logic of these modes uses it.
            pll_divider_select_q <= ctrl_new[`CDL_PLL_DIVIDER_SELECT_MSB:`CDL_PLL_DIVIDER_SELECT_LSB];
         end
         if (incr_wr) begin
            incr_q <= merge_sel(incr_q, wb_dat_i, wb_sel_i);
         end
         if (pin_wr) begin
            dir_a_q <= pin_new[`CDL_PC_DIR_A];
            dir_b_q <= pin_new[`CDL_PC_DIR_B];
            lat_a_q <= pin_new[`CDL_PC_LAT_A];
            lat_b_q <= pin_new[`CDL_PC_LAT_B];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Pin sampling
   // -------------------------------------------------------------------------
   // input registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_s1_q  <= 1'b0;
         first_s2_q  <= 1'b0;
         second_s1_q <= 1'b0;
      end else begin
         first_s1_q  <= first_pin_i;
         first_s2_q  <= first_s1_q;
         second_s1_q <= second_pin_i;
      end
   end

   // -------------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------------
   cdl_pkg::cdl_pins_t pins;
   cdl_pkg::cdl_cond_t cond;

   assign pins.a_s1 = first_s1_q;
   assign pins.a_s2 = first_s2_q;
   assign pins.b_s1 = second_s1_q;

   cdl_cond u_cond (
      .mode_i (mode_q),
      .pins_i (pins),
      .cond_o (cond)
   );

   // -------------------------------------------------------------------------
   // Accumulator
   // -------------------------------------------------------------------------
   wire logic [32:0] sum;
   wire logic        carry;
   wire logic        drv_a;
   wire logic        drv_b;

   // carry out of the add
   // The carry is high in a share of cycles equal to increment / 2^32.
   assign sum   = {1'b0, acc_q} + {1'b0, incr_q};
   assign carry = cond.duty & sum[32];

   // conditional add
   // A software write to the accumulator wins over the add in that cycle.
   assign acc_d = acc_wr          ? merge_sel(acc_q, wb_dat_i, wb_sel_i) :
                  cond.accumulate ? sum[31:0] : acc_q;

   assign drv_a = carry;
   assign drv_b = (cond.diff & ~sum[32]) | (cond.feedback & ~first_s1_q);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= `CDL_RST_WORD;
      end else begin
         acc_q <= acc_d;
      end
   end

   // -------------------------------------------------------------------------
   // Pin drivers
   // -------------------------------------------------------------------------
   // latch OR, direction enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_a_q <= 1'b0;
         pin_b_q <= 1'b0;
      end else begin
         pin_a_q <= drv_a | lat_a_q;
         pin_b_q <= drv_b | lat_b_q;
      end
   end

   assign wb_ack_o        = ack_q;
   assign wb_dat_o        = dat_q;
   assign first_pin_o     = pin_a_q;
   assign second_pin_o    = pin_b_q;
   assign first_pin_oe_o  = dir_a_q;
   assign second_pin_oe_o = dir_b_q;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   wire logic duty_now;
   wire logic logic_now;

   assign duty_now  = (mode_q == `CDL_MODE_DUTY_SE) || (mode_q == `CDL_MODE_DUTY_DF);
   assign logic_now = mode_q[4];

   property p_duty_wrap;
      @(posedge clk_i) disable iff (rst_i)
      (duty_now && !acc_wr) |=>
         (first_pin_o == ((acc_q < $past(acc_q)) | $past(lat_a_q)));
   endproperty
   a_duty_wrap: assert property (p_duty_wrap) else $error("duty pin not on wrap");

   property p_duty_add;
      @(posedge clk_i) disable iff (rst_i)
      (duty_now && !acc_wr) |=> (acc_q == 32'($past(acc_q) + $past(incr_q)));
   endproperty
   a_duty_add: assert property (p_duty_add) else $error("duty add missing");

   property p_never;
      @(posedge clk_i) disable iff (rst_i)
      ((mode_q == `CDL_MODE_NEVER || mode_q == `CDL_MODE_OFF) && !acc_wr) |=> $stable(acc_q);
   endproperty
   a_never: assert property (p_never) else $error("never mode accumulated");

   property p_always;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q == `CDL_MODE_ALWAYS && !acc_wr) |=> (acc_q == 32'($past(acc_q) + $past(incr_q)));
   endproperty
   a_always: assert property (p_always) else $error("always mode skipped");

   property p_logic_eq;
      @(posedge clk_i) disable iff (rst_i)
      (logic_now && !acc_wr && incr_q != 32'h0000_0000) |=>
         ((acc_q != $past(acc_q)) ==
          ((($past(mode_q) >> {$past(second_pin_i, 2), $past(first_pin_i, 2)}) & 5'h01)
           != 5'h00));
   endproperty
   a_logic_eq: assert property (p_logic_eq) else $error("logic equation mismatch");

   property p_rise;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q[4:1] == 4'h5 && !acc_wr && incr_q != 32'h0000_0000) |=>
         ((acc_q != $past(acc_q)) == ($past(first_pin_i, 2) && !$past(first_pin_i, 3)));
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge count wrong");

   property p_low;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q[4:1] == 4'h6 && !acc_wr && incr_q != 32'h0000_0000) |=>
         ((acc_q != $past(acc_q)) == !$past(first_pin_i, 2));
   endproperty
   a_low: assert property (p_low) else $error("low level count wrong");

   property p_feedback;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q[4:3] == 2'b01 && mode_q[0]) |=>
         (second_pin_o == (!$past(first_pin_i, 2) || $past(lat_b_q)));
   endproperty
   a_feedback: assert property (p_feedback) else $error("feedback not inverse");

   property p_diff;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q == `CDL_MODE_DUTY_DF && !lat_a_q && !lat_b_q) |=> (second_pin_o != first_pin_o);
   endproperty
   a_diff: assert property (p_diff) else $error("differential pins equal");

   property p_latch;
      @(posedge clk_i) disable iff (rst_i)
      (lat_a_q && !pin_wr) |=> (first_pin_o && first_pin_oe_o == $past(dir_a_q));
   endproperty
   a_latch: assert property (p_latch) else $error("latch not ORed on pin");

   property p_high;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q[4:1] == 4'h4 && !acc_wr && incr_q != 32'h0000_0000) |=>
         ((acc_q != $past(acc_q)) == $past(first_pin_i, 2));
   endproperty
   a_high: assert property (p_high) else $error("high level count wrong");

   property p_fall;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q[4:1] == 4'h7 && !acc_wr && incr_q != 32'h0000_0000) |=>
         ((acc_q != $past(acc_q)) == (!$past(first_pin_i, 2) && $past(first_pin_i, 3)));
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge count wrong");

   property p_logic_in;
      @(posedge clk_i) disable iff (rst_i)
      logic_now |=> (first_pin_o == $past(lat_a_q) && second_pin_o == $past(lat_b_q));
   endproperty
   a_logic_in: assert property (p_logic_in) else $error("logic mode drove a pin");

endmodule

`default_nettype wire

// ---- test/cdl_pin_model.sv ----
// Purpose: External side of one counter pin: a source seen through a resistor.
// Assumes: The counter wins the line whenever its output enable is high.
// Notes:   While released, the line follows the outside source, never the last drive.
`timescale 1ns/100ps
`default_nettype none

module cdl_pin_model (
   // Counter side
   input  wire logic drv_i,
   input  wire logic drv_oe_i,
   // Outside source
   input  wire logic ext_i,
   // Line level
   output logic      pin_o
);
   assign pin_o = drv_oe_i ? drv_i : ext_i;
endmodule

`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the counter duty, logic and pin-state modes.
// Assumes: A cycle model here predicts register reads and pin outputs.
// Notes:   Pin levels are random from a fixed seed; increment, accumulator and pin control too, except in sweep pass 1.
`timescale 1ns/100ps
`default_nettype none
`include "cdl_consts.svh"

module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0, wb_rdat, d;
   logic        wb_ack, ext_a = 1'b0, ext_b = 1'b0, pin_a, pin_b;
   logic        first_pin_o, first_pin_oe_o, second_pin_o, second_pin_oe_o;
   integer      seed = 32'hAE614358;
   int          num_errors = 0, n_compared = 0, cycles = 0;
   logic [31:0] m_ctrl, m_incr, m_acc, rd_exp;
   logic [3:0]  m_pc;
   logic        m_a1, m_a2, m_b1, e_first, e_second, m_skip, wr;
   logic [32:0] sum;
   logic [4:0]  mode;

   always #12.5 clk_i = ~clk_i;

   cdl_counter cdl_counter_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .first_pin_i(pin_a),
      .first_pin_o(first_pin_o), .first_pin_oe_o(first_pin_oe_o), .second_pin_i(pin_b),
      .second_pin_o(second_pin_o), .second_pin_oe_o(second_pin_oe_o));
   cdl_pin_model pin_a_inst (.drv_i(first_pin_o), .drv_oe_i(first_pin_oe_o), .ext_i(ext_a),
      .pin_o(pin_a));
   cdl_pin_model pin_b_inst (.drv_i(second_pin_o), .drv_oe_i(second_pin_oe_o),
      .ext_i(ext_b), .pin_o(pin_b));

   // ---------------------------------------------------------------------------
   // Cycle model
   // ---------------------------------------------------------------------------
   function automatic logic cond_of(input logic [4:0] m, input logic a1, a2, b1);
      if (m[4])
         return m[{b1, a1}];
      if (m[4:3] == 2'b01) begin
         case (m[2:1])
            2'd0: return a1;
            2'd1: return a1 & ~a2;
            2'd2: return ~a1;
            default: return ~a1 & a2;
         endcase
      end
      return m[4:1] == 4'b0011;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         if (s[i]) o[8*i +: 8] = n[8*i +: 8];
      return o;
   endfunction

   function automatic logic [31:0] rd_word(input logic [7:0] a);
      case (a)
         `CDL_OFS_CTRL:   return m_ctrl & 32'h7F80_0000;
         `CDL_OFS_INCR:   return m_incr;
         `CDL_OFS_ACCUM:  return m_acc;
         `CDL_OFS_PINCTL: return {26'h0, m_b1, m_a1, m_pc};
         default:         return 32'h0;
      endcase
   endfunction

   assign mode = m_ctrl[`CDL_MODE_MSB:`CDL_MODE_LSB];
   assign sum  = {1'b0, m_acc} + {1'b0, m_incr};
   assign wr   = wb_cyc & wb_stb & wb_we & wb_ack;

   always @(posedge clk_i) begin
      ext_a <= 1'($random(seed));
      ext_b <= 1'($random(seed));
      if (rst_i) begin
         {m_ctrl, m_incr, m_acc, rd_exp, m_pc} <= '0;
         {m_a1, m_a2, m_b1, e_first, e_second, m_skip} <= '0;
      end else begin
         m_a1 <= pin_a;
         m_a2 <= m_a1;
         m_b1 <= pin_b;
         m_skip <= wr;
         e_first <= ((mode[4:1] == 4'b0011) & sum[32]) | m_pc[2];
         e_second <= m_pc[3] | ((mode == `CDL_MODE_DUTY_DF) & ~sum[32])
                   | ((mode[4:3] == 2'b01) & mode[0] & ~m_a1);
         if (wb_cyc & wb_stb & ~wb_we & ~wb_ack)
            rd_exp <= rd_word(wb_adr);
         if (wr & (wb_adr == `CDL_OFS_ACCUM))
            m_acc <= merge(m_acc, wb_wdat, wb_sel);
         else if (cond_of(mode, m_a1, m_a2, m_b1))
            m_acc <= sum[31:0];
         if (wr & (wb_adr == `CDL_OFS_CTRL))
            m_ctrl <= merge(m_ctrl, wb_wdat, wb_sel);
         if (wr & (wb_adr == `CDL_OFS_INCR))
            m_incr <= merge(m_incr, wb_wdat, wb_sel);
         if (wr & (wb_adr == `CDL_OFS_PINCTL) & wb_sel[0])
            m_pc <= wb_wdat[3:0];
      end
   end

   // ---------------------------------------------------------------------------
   // Checks and bus tasks
   // ---------------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   always @(negedge clk_i) begin
      if (!rst_i && !m_skip) begin
         chk({30'h0, second_pin_oe_o, first_pin_oe_o}, {30'h0, m_pc[1:0]});
         if (m_pc[0]) chk({31'h0, first_pin_o}, {31'h0, e_first});
         if (m_pc[1]) chk({31'h0, second_pin_o}, {31'h0, e_second});
      end
   end

   task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] dat);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_wdat <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1);
      chk(32'(n), 32'h0000_0002);
      if (!we) chk(wb_rdat, rd_exp);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic rd_all(input logic [7:0] unm);
      for (int i = 0; i < 4; i++)
         xfer(1'b0, 8'(4 * i), 4'hF, 32'h0);
      xfer(1'b0, unm, 4'hF, 32'h0);
   endtask

   task automatic end_of_test();
      $display("Counts: compared=%0d errors=%0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_all(8'h10);
      $display("test reset values done");
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 32; m++) begin
            d = $random(seed);
            d[`CDL_MODE_MSB:`CDL_MODE_LSB] = 5'(m);
            xfer(1'b1, `CDL_OFS_CTRL, 4'hF, 32'h0);
            xfer(1'b1, `CDL_OFS_INCR, p ? 4'hF : 4'($random(seed)), p ? 32'h1 : $random(seed));
            xfer(1'b1, `CDL_OFS_ACCUM, 4'hF, p ? 32'hFFFF_FFF0 : $random(seed));
            xfer(1'b1, `CDL_OFS_PINCTL, 4'hF, p ? 32'h0000_0003 : $random(seed));
            xfer(1'b1, `CDL_OFS_CTRL, 4'hF, d);
            repeat (40) @(posedge clk_i);
            rd_all(8'(8'h10 + 4 * m));
         end
         $display("test mode sweep pass %0d done", p);
      end
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_all(8'h01);
      $display("test reset in mid-run done");
      end_of_test();
   end
endmodule

`default_nettype wire
